/* File: lwc_pkg.sv */
/*
 * shared constants and types of the wafer calculator: register map,
 * field layout, input source codes, timing.
 * assumes a 250 MHz clock and an axi4-lite register bus.
 */
package lwc_pkg;

   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int          NUM_WAFERS = 10;
   localparam int          RES_BITS   = 40;
   localparam int          SRC_BITS   = 275;
   localparam logic [8:0]  SEL_MAX    = 9'h15B;
   localparam logic [2:0]  FUNC_MIN   = 3'h1;
   localparam logic [2:0]  FUNC_MAX   = 3'h6;
   localparam logic [15:0] CONST_BAD  = 16'h8000;

   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_RES_LO = 12'h008;
   localparam logic [11:0] OFS_RES_HI = 12'h00C;
   localparam logic [11:0] OFS_DOUT   = 12'h010;
   localparam logic [11:0] OFS_WAFER  = 12'h040;
   localparam logic [11:0] OFS_CONST  = 12'h080;

   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int          CFG_A_LSB  = 0;
   localparam int          CFG_B_LSB  = 9;
   localparam int          CFG_C_LSB  = 18;
   localparam int          CFG_FN_LSB = 28;
   localparam int          DSEL_EN    = 7;
   localparam logic [31:0] CFG_RST    = 32'h1000_0000;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;

   // ------------------------------------------------------------
   // operand source codes
   // ------------------------------------------------------------
   localparam logic [8:0] CODE_ALM_LO   = 9'h003;
   localparam logic [8:0] CODE_ALM_HI   = 9'h007;
   localparam logic [8:0] CODE_EV_LO    = 9'h014;
   localparam logic [8:0] CODE_EV_HI    = 9'h018;
   localparam logic [8:0] CODE_RES_LO   = 9'h01E;
   localparam logic [8:0] CODE_RES_HI   = 9'h045;
   localparam logic [8:0] CODE_CON_LO   = 9'h046;
   localparam logic [8:0] CODE_CON_HI   = 9'h04F;
   localparam logic [8:0] CODE_UNDER    = 9'h05E;
   localparam logic [8:0] CODE_OVER     = 9'h05F;
   localparam logic [8:0] CODE_RANGE    = 9'h062;
   localparam logic [8:0] CODE_INERR    = 9'h067;
   localparam logic [8:0] CODE_AUTOMAN  = 9'h068;
   localparam logic [8:0] CODE_RUNSTBY  = 9'h069;
   localparam logic [8:0] CODE_AT_RUN   = 9'h06A;
   localparam logic [8:0] CODE_AT_NORM  = 9'h06C;
   localparam logic [8:0] CODE_AT_LOW   = 9'h06D;
   localparam logic [8:0] CODE_STEP_LO  = 9'h0AA;
   localparam logic [8:0] CODE_STEP_HI  = 9'h129;
   localparam logic [8:0] CODE_REL_LO   = 9'h12C;
   localparam logic [8:0] CODE_REL_HI   = 9'h1AB;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_KHZ       = 250000;
   localparam int CTL_CYCLE_MS  = 100;
   localparam int CTL_CYCLE_CYC = CTL_CYCLE_MS * CLK_KHZ;

   typedef enum logic [1:0] {
      LWC_IDLE = 2'b01,
      LWC_EVAL = 2'b10
   } lwc_fsm_e;

endpackage

/* File: lwc_src_if.sv */
/*
 * carrier between the calculator core and the wafer evaluator:
 * source flags, one wafer's configuration and its four results.
 * assumes both ends sit on the same clock.
 */
`timescale 1ns/1ns
interface lwc_src_if;
   logic [4:0]   alarm;
   logic [4:0]   event_st;
   logic [4:0]   op_st;
   logic [3:0]   in_err;
   logic [127:0] step_ts;
   logic [127:0] rel_ts;
   logic [39:0]  result;
   logic [9:0]   const_nz;
   logic [2:0]   func;
   logic [8:0]   sel_a;
   logic [8:0]   sel_b;
   logic [8:0]   sel_c;
   logic [3:0]   out;

   modport core (output alarm, event_st, op_st, in_err, step_ts, rel_ts, result, const_nz,
                 output func, sel_a, sel_b, sel_c, input out);
   modport eval (input alarm, event_st, op_st, in_err, step_ts, rel_ts, result, const_nz,
                 input func, sel_a, sel_b, sel_c, output out);
endinterface // lwc_src_if

/* File: lwc_sync.sv */
/*
 * three-flop synchroniser for a vector of pin levels; a bit changes
 * once the second and third stages agree.
 * assumes the pins are quasi-static levels.
 */
`timescale 1ns/1ns
module lwc_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // pins and clean levels
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] level_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } lwc_sync_s;

   lwc_sync_s st_reg;
   lwc_sync_s st_next;

   // shift and accept bits whose last two stages agree
   always_comb begin
      st_next    = st_reg;
      st_next.s1 = pin_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.q  = (~(st_reg.s2 ^ st_reg.s3) & st_reg.s3) | ((st_reg.s2 ^ st_reg.s3) & st_reg.q);
   end

   // state register
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign level_out = st_reg.q;
endmodule // lwc_sync

/* File: lwc_wafer_eval.sv */
/*
 * combinational evaluator of one wafer: decodes the three operand
 * codes and forms the four results of the chosen function type.
 * assumes the core presents one wafer's configuration at a time.
 */
`timescale 1ns/1ns
module lwc_wafer_eval (
   // sources, configuration and results
   lwc_src_if.eval src
);
   logic a;
   logic b;
   logic c;

   // operand decode of one source code
   function automatic logic pick(input logic [8:0] code);
      logic r;
      r = 1'b0;
      // RULE5 alarm codes
      if (code >= lwc_pkg::CODE_ALM_LO && code <= lwc_pkg::CODE_ALM_HI) begin
         r = src.alarm[3'(code - lwc_pkg::CODE_ALM_LO)];
      end
      // RULE6 event codes
      if (code >= lwc_pkg::CODE_EV_LO && code <= lwc_pkg::CODE_EV_HI) begin
         r = src.event_st[3'(code - lwc_pkg::CODE_EV_LO)];
      end
      // RULE4 wafer result codes
      if (code >= lwc_pkg::CODE_RES_LO && code <= lwc_pkg::CODE_RES_HI) begin
         r = src.result[6'(code - lwc_pkg::CODE_RES_LO)];
      end
      // RULE12 nonzero constant
      if (code >= lwc_pkg::CODE_CON_LO && code <= lwc_pkg::CODE_CON_HI) begin
         r = src.const_nz[4'(code - lwc_pkg::CODE_CON_LO)];
      end
      // RULE10 control status operands
      if (code == lwc_pkg::CODE_UNDER)   r = src.in_err[0];
      if (code == lwc_pkg::CODE_OVER)    r = src.in_err[1];
      if (code == lwc_pkg::CODE_RANGE)   r = src.in_err[2];
      if (code == lwc_pkg::CODE_INERR)   r = src.in_err[3];
      if (code == lwc_pkg::CODE_AUTOMAN) r = src.op_st[0];
      if (code == lwc_pkg::CODE_RUNSTBY) r = src.op_st[1];
      if (code == lwc_pkg::CODE_AT_RUN)  r = src.op_st[2];
      // RULE7 auto-tuning start-up type
      if (code == lwc_pkg::CODE_AT_NORM) r = src.op_st[3];
      if (code == lwc_pkg::CODE_AT_LOW)  r = src.op_st[4];
      // RULE8 step time signals
      if (code >= lwc_pkg::CODE_STEP_LO && code <= lwc_pkg::CODE_STEP_HI) begin
         r = src.step_ts[7'(code - lwc_pkg::CODE_STEP_LO)];
      end
      // RULE9 relative step time signals
      if (code >= lwc_pkg::CODE_REL_LO && code <= lwc_pkg::CODE_REL_HI) begin
         r = src.rel_ts[7'(code - lwc_pkg::CODE_REL_LO)];
      end
      return r;
   endfunction

   assign a = pick(src.sel_a);
   assign b = pick(src.sel_b);
   assign c = pick(src.sel_c);

   // RULE3 RULE14 per-type result table
   always_comb begin
      case (src.func)
         3'h1: src.out = {~(a & b & ~c), a & b & ~c, ~(a & b & c), a & b & c};
         3'h2: src.out = {~(a | b | ~c), a | b | ~c, ~(a | b | c), a | b | c};
         3'h3: src.out = {a & b & c, a & b & ~c, a & b & c, a | b | c};
         3'h4: src.out = {~((a | b) & c), (a | b) & c, (a | b) & c, a | b | c};
         3'h5: src.out = {(a & b) | c, a | b | ~c, ~((a & b) | c), (a & b) | c};
         3'h6: src.out = {~(a ^ b ^ c), a ^ b ^ c, ~((a & b) ^ c), (a & b) ^ c};
         default: src.out = 4'h0;
      endcase
   end
endmodule // lwc_wafer_eval

/* File: lwc_calc.sv */
/*
 * wafer calculator core: axi4-lite register file, control-cycle
 * divider, wafer sequencer, result store and discrete outputs.
 * assumes status pins are asynchronous levels and one bus master.
 */
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns

// Overview of operation
// RULE1 - global enable; off means no wafer evaluates and results hold
// RULE2 - ten wafers, each configured and evaluated on its own
// RULE3 - function selector per wafer accepts 1 to 6 only
// RULE4 - codes 30..69 read wafer results, four per wafer, ascending
// RULE5 - code 0 reads zero, codes 3..7 read alarms one to five
// RULE6 - codes 20..24 read off, run, hold, guarantee soak, end events
// RULE7 - codes 108 and 109 read auto-tuning normal and low start-up
// RULE8 - codes 170..297 read step ramp on even, soak on odd
// RULE9 - codes 300..427 read relative step ramp even, soak odd
// RULE10 - results drive discrete outputs; alarms and status are operands
// RULE11 - three operand selectors per wafer, each accepting 0 to 347
// RULE12 - ten signed constants within -32767 to 32767 as operands
// RULE13 - four readable result bits per wafer
// RULE14 - each type forms fixed combinations of A, B, C with inversions
// RULE15 - wafers evaluate in ascending order within one control cycle
module lwc_calc #(
   parameter int unsigned CTL_CYCLE_CYC = lwc_pkg::CTL_CYCLE_CYC
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         arst_n,
   // axi4-lite write
   input  wire logic [11:0]  s_axi_awaddr,
   input  wire logic         s_axi_awvalid,
   output logic              s_axi_awready,
   input  wire logic [31:0]  s_axi_wdata,
   input  wire logic [3:0]   s_axi_wstrb,
   input  wire logic         s_axi_wvalid,
   output logic              s_axi_wready,
   output logic [1:0]        s_axi_bresp,
   output logic              s_axi_bvalid,
   input  wire logic         s_axi_bready,
   // axi4-lite read
   input  wire logic [11:0]  s_axi_araddr,
   input  wire logic         s_axi_arvalid,
   output logic              s_axi_arready,
   output logic [31:0]       s_axi_rdata,
   output logic [1:0]        s_axi_rresp,
   output logic              s_axi_rvalid,
   input  wire logic         s_axi_rready,
   // status pins
   input  wire logic [4:0]   alarm_in,
   input  wire logic [4:0]   event_in,
   input  wire logic [4:0]   op_status_in,
   input  wire logic [3:0]   input_error_in,
   input  wire logic [127:0] step_time_in,
   input  wire logic [127:0] rel_time_in,
   // discrete outputs
   output logic [3:0]        discrete_out
);
   typedef struct packed {
      logic              calc_enable;
      lwc_pkg::lwc_fsm_e fsm;
      logic [3:0]        idx;
      logic [31:0]       tick_cnt;
      logic [15:0]       passes;
      logic [9:0][31:0]  cfg;
      logic [9:0][15:0]  calc_constant;
      logic [39:0]       result;
      logic [3:0][7:0]   dsel;
      logic [3:0]        dout;
      logic              aw_have;
      logic [11:0]       awaddr;
      logic              w_have;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } lwc_state_s;

   lwc_state_s st_reg;
   lwc_state_s st_next;
   logic [274:0] pins;
   logic         tick;
   logic [9:0]   const_nz;
   lwc_src_if    src ();

   // ------------------------------------------------------------
   // pin synchroniser and evaluator
   // ------------------------------------------------------------
   lwc_sync #(.W(lwc_pkg::SRC_BITS)) u_sync (
      .clk       (clk),
      .arst_n    (arst_n),
      .pin_in    ({alarm_in, event_in, op_status_in, input_error_in, step_time_in, rel_time_in}),
      .level_out (pins)
   );

   lwc_wafer_eval u_eval (
      .src (src.eval)
   );

   // constant operands read as true when nonzero
   always_comb begin
      for (int k = 0; k < lwc_pkg::NUM_WAFERS; k++) begin
         const_nz[k] = |st_reg.calc_constant[k];
      end
   end

   // present the wafer under evaluation
   assign src.alarm    = pins[274:270];
   assign src.event_st = pins[269:265];
   assign src.op_st    = pins[264:260];
   assign src.in_err   = pins[259:256];
   assign src.step_ts  = pins[255:128];
   assign src.rel_ts   = pins[127:0];
   assign src.result   = st_reg.result;
   assign src.const_nz = const_nz;
   assign src.func     = st_reg.cfg[st_reg.idx][lwc_pkg::CFG_FN_LSB +: 3];
   assign src.sel_a    = st_reg.cfg[st_reg.idx][lwc_pkg::CFG_A_LSB +: 9];
   assign src.sel_b    = st_reg.cfg[st_reg.idx][lwc_pkg::CFG_B_LSB +: 9];
   assign src.sel_c    = st_reg.cfg[st_reg.idx][lwc_pkg::CFG_C_LSB +: 9];

   assign tick = (st_reg.tick_cnt == 32'(CTL_CYCLE_CYC - 1));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // byte-lane merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction

   // wafer config legality
   function automatic logic cfg_ok(input logic [31:0] v);
      logic [2:0] fn;
      fn = v[lwc_pkg::CFG_FN_LSB +: 3];
      return fn >= lwc_pkg::FUNC_MIN && fn <= lwc_pkg::FUNC_MAX
             && v[lwc_pkg::CFG_A_LSB +: 9] <= lwc_pkg::SEL_MAX
             && v[lwc_pkg::CFG_B_LSB +: 9] <= lwc_pkg::SEL_MAX
             && v[lwc_pkg::CFG_C_LSB +: 9] <= lwc_pkg::SEL_MAX;
   endfunction

   // register read decode, bit 32 flags an unmapped address
   function automatic logic [32:0] rd(input lwc_state_s s, input logic [11:0] a);
      logic [32:0] r;
      logic [11:0] o;
      r = {1'b1, 32'h0000_0000};
      o = a - lwc_pkg::OFS_WAFER;
      // RULE2 RULE11 wafer config readback
      if (a >= lwc_pkg::OFS_WAFER && o < 12'h028 && a[1:0] == 2'h0) begin
         r = {1'b0, s.cfg[o[5:2]]};
      end
      o = a - lwc_pkg::OFS_CONST;
      if (a >= lwc_pkg::OFS_CONST && o < 12'h028 && a[1:0] == 2'h0) begin
         r = {1'b0, {16{s.calc_constant[o[5:2]][15]}}, s.calc_constant[o[5:2]]};
      end
      case (a)
         lwc_pkg::OFS_CTRL:   r = {1'b0, 31'h0000_0000, s.calc_enable};
         lwc_pkg::OFS_STATUS: r = {1'b0, s.passes, 8'h00, s.dout, 3'h0, s.fsm == lwc_pkg::LWC_EVAL};
         // RULE13 result readback
         lwc_pkg::OFS_RES_LO: r = {1'b0, s.result[31:0]};
         lwc_pkg::OFS_RES_HI: r = {1'b0, 24'h00_0000, s.result[39:32]};
         lwc_pkg::OFS_DOUT:   r = {1'b0, s.dsel};
         default: ;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic [32:0] rv;
      logic [31:0] wv;
      logic [11:0] o;
      logic [5:0]  ri;
      st_next = st_reg;
      rv      = '0;
      wv      = '0;
      o       = '0;
      ri      = '0;

      // control cycle divider
      st_next.tick_cnt = tick ? 32'h0000_0000 : st_reg.tick_cnt + 32'h0000_0001;

      // wafer sequencer
      case (st_reg.fsm)
         lwc_pkg::LWC_IDLE: begin
            // RULE1 start only when enabled
            if (tick && st_reg.calc_enable) begin
               st_next.fsm = lwc_pkg::LWC_EVAL;
               st_next.idx = 4'h0;
            end
         end
         lwc_pkg::LWC_EVAL: begin
            if (!st_reg.calc_enable) begin
               // RULE1 abort holds results
               st_next.fsm = lwc_pkg::LWC_IDLE;
               st_next.idx = 4'h0;
            end else begin
               // RULE15 ascending, result visible next
               st_next.result[6'(st_reg.idx * 4) +: 4] = src.out;
               if (st_reg.idx == 4'(lwc_pkg::NUM_WAFERS - 1)) begin
                  st_next.fsm    = lwc_pkg::LWC_IDLE;
                  st_next.idx    = 4'h0;
                  st_next.passes = st_reg.passes + 16'h0001;
               end else begin
                  st_next.idx = st_reg.idx + 4'h1;
               end
            end
         end
         default: begin
            st_next.fsm = lwc_pkg::LWC_IDLE;
            st_next.idx = 4'h0;
         end
      endcase

      // RULE10 discrete outputs from results
      for (int k = 0; k < 4; k++) begin
         ri = st_reg.dsel[k][5:0];
         st_next.dout[k] = st_reg.dsel[k][lwc_pkg::DSEL_EN] && ri < 6'(lwc_pkg::RES_BITS)
                           && st_reg.result[ri];
      end

      // write address and data capture
      if (s_axi_awvalid && st_reg.awready) begin
         st_next.aw_have = 1'b1;
         st_next.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_reg.wready) begin
         st_next.w_have = 1'b1;
         st_next.wdata  = s_axi_wdata;
         st_next.wstrb  = s_axi_wstrb;
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end

      // register write once both halves are held
      if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
         st_next.aw_have = 1'b0;
         st_next.w_have  = 1'b0;
         st_next.bvalid  = 1'b1;
         rv              = rd(st_reg, st_reg.awaddr);
         wv              = merge(rv[31:0], st_reg.wdata, st_reg.wstrb);
         st_next.bresp   = rv[32] ? lwc_pkg::RESP_SLV : lwc_pkg::RESP_OKAY;
         if (st_reg.awaddr == lwc_pkg::OFS_CTRL) begin
            st_next.calc_enable = wv[0];
         end
         if (st_reg.awaddr == lwc_pkg::OFS_DOUT) begin
            st_next.dsel = wv;
         end
         o = st_reg.awaddr - lwc_pkg::OFS_WAFER;
         // RULE3 RULE11 illegal config words ignored
         if (!rv[32] && st_reg.awaddr >= lwc_pkg::OFS_WAFER && o < 12'h028 && cfg_ok(wv)) begin
            st_next.cfg[o[5:2]] = wv;
         end
         o = st_reg.awaddr - lwc_pkg::OFS_CONST;
         // RULE12 out-of-range constant ignored
         if (!rv[32] && st_reg.awaddr >= lwc_pkg::OFS_CONST && o < 12'h028
             && wv[15:0] != lwc_pkg::CONST_BAD) begin
            st_next.calc_constant[o[5:2]] = wv[15:0];
         end
      end
      st_next.awready = !st_next.aw_have && !st_next.bvalid;
      st_next.wready  = !st_next.w_have && !st_next.bvalid;

      // read channel
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_reg.arready) begin
         rv             = rd(st_reg, s_axi_araddr);
         st_next.rvalid = 1'b1;
         st_next.rdata  = rv[31:0];
         st_next.rresp  = rv[32] ? lwc_pkg::RESP_SLV : lwc_pkg::RESP_OKAY;
      end
      st_next.arready = !st_next.rvalid;
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg         <= '0;
         st_reg.fsm     <= lwc_pkg::LWC_IDLE;
         st_reg.cfg     <= {lwc_pkg::NUM_WAFERS{lwc_pkg::CFG_RST}};
         st_reg.awready <= 1'b1;
         st_reg.wready  <= 1'b1;
         st_reg.arready <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flops
   assign s_axi_awready = st_reg.awready;
   assign s_axi_wready  = st_reg.wready;
   assign s_axi_bvalid  = st_reg.bvalid;
   assign s_axi_bresp   = st_reg.bresp;
   assign s_axi_arready = st_reg.arready;
   assign s_axi_rvalid  = st_reg.rvalid;
   assign s_axi_rdata   = st_reg.rdata;
   assign s_axi_rresp   = st_reg.rresp;
   assign discrete_out  = st_reg.dout;
endmodule // lwc_calc

/* File: lwc_calc_sva.sv */
/* checker of the register bus handshakes of the calculator.
   assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ns
module lwc_calc_sva (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // write side
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read side
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // both write halves taken, read address taken
   sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
   sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
   a_wr_answer: assert property (s_wr_take |=> ##1 s_axi_bvalid)
      else $error("write answer late");
   a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
      else $error("write answer kept");
   a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read answer dropped");
   a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read answer kept");
   a_r_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready))
      else $error("read answer unasked");
endmodule // lwc_calc_sva

/* File: lwc_src_model.sv */
/* status source model: raises the one pin behind an alarm, event, under-range, auto-tuning start-up, step or relative step code.
   assumes the bench picks the code. */
`timescale 1ns/1ns
module lwc_src_model (
   // operand code to light
   input wire logic [8:0] code,
   // status pins
   output logic [4:0]   alarm_in,
   output logic [4:0]   event_in,
   output logic [4:0]   op_status_in,
   output logic [3:0]   input_error_in,
   output logic [127:0] step_time_in,
   output logic [127:0] rel_time_in
);
   // at most one pin high, the rest low
   always_comb begin
      {alarm_in, event_in, op_status_in, step_time_in, rel_time_in} = '0;
      input_error_in = {3'h0, code == 9'h05E};
      if (code inside {[9'h003:9'h007]}) alarm_in[code - 9'h003] = 1'b1;
      if (code inside {[9'h014:9'h018]}) event_in[code - 9'h014] = 1'b1;
      if (code inside {9'h06C, 9'h06D}) op_status_in[code - 9'h069] = 1'b1;
      if (code inside {[9'h0AA:9'h129]}) step_time_in[code - 9'h0AA] = 1'b1;
      if (code inside {[9'h12C:9'h1AB]}) rel_time_in[code - 9'h12C] = 1'b1;
   end
endmodule // lwc_src_model

/* File: lwc_calc_bench.sv */
/* bench of the calculator: axi4-lite tasks and scenarios.
   assumes the source model and a 20-clock control cycle. */
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
   $display("ERROR %0t: %h not %h", $time, g, e); end end
module lwc_calc_bench;
   logic         clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0]  s_axi_wdata, s_axi_rdata, d;
   logic [1:0]   s_axi_bresp, s_axi_rresp, r;
   logic [3:0]   s_axi_wstrb, input_error_in, discrete_out;
   logic [4:0]   alarm_in, event_in, op_status_in;
   logic [127:0] step_time_in, rel_time_in;
   logic [8:0]   code;
   int           err_count, total_checks, k;
   logic [8:0]   codes[14] = '{9'h000, 9'h007, 9'h014, 9'h017, 9'h018, 9'h046, 9'h04F,
                               9'h05E, 9'h06C, 9'h06D, 9'h0AA, 9'h129, 9'h15B, 9'h003};
   localparam logic [11:0] WF = lwc_pkg::OFS_WAFER;
   localparam logic [11:0] CK = lwc_pkg::OFS_CONST + 12'h024;
   // clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   lwc_calc #(.CTL_CYCLE_CYC(20)) dut (.*);
   lwc_src_model u_src (.*);
   // verdict and end of run
   task automatic print_verdict;
      if (err_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic hang;
      err_count++;
      $display("ERROR %0t: no answer", $time);
      print_verdict;
   endtask
   // write, both halves offered together
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      repeat (50) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
            return;
         end
      end
      hang;
   endtask
   // read, answer taken at the handshake edge
   task automatic rd(input logic [11:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      repeat (50) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            s_axi_rready <= 1'b0;
            return;
         end
      end
      hang;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      rd(a);
      `CHK(d, e)
      `CHK(r, lwc_pkg::RESP_OKAY)
   endtask
   function automatic logic [31:0] cfg(input logic [2:0] f, input logic [8:0] a);
      return {1'b0, f, 19'h00000, a};
   endfunction
   // scenarios
   initial begin
      arst_n = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, code} = '0;
      s_axi_wstrb = 4'hF;
      err_count = 0;
      total_checks = 0;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      rdc(lwc_pkg::OFS_CTRL, 32'h0);
      rd(12'h0FC);
      `CHK(r, lwc_pkg::RESP_SLV)
      wr(12'h0FC, 32'h1);
      `CHK(r, lwc_pkg::RESP_SLV)
      wr(WF, cfg(3'h7, 9'h000));
      rdc(WF, lwc_pkg::CFG_RST);
      for (k = 1; k <= 6; k++) begin
         wr(WF + 12'h004, cfg(3'(k), 9'h15B));
         rdc(WF + 12'h004, cfg(3'(k), 9'h15B));
      end
      wr(WF + 12'h004, cfg(3'h6, 9'h15C));
      rdc(WF + 12'h004, cfg(3'h6, 9'h15B));
      wr(CK, 32'h0000_FFFF);
      wr(CK, 32'h0000_8000);
      rdc(CK, 32'hFFFF_FFFF);
      // each listed source code through the first wafer
      wr(lwc_pkg::OFS_CTRL, 32'h1);
      foreach (codes[i]) begin
         code <= codes[i];
         wr(WF, cfg(3'h2, codes[i]));
         repeat (60) @(posedge clk);
         rd(lwc_pkg::OFS_RES_LO);
         `CHK(d[3:0], (codes[i] inside {9'h000, 9'h046}) ? 4'h6 : 4'h5)
      end
      // all six types on alarm 1, ending on type 2
      for (k = 1; k <= 6; k++) begin
         wr(WF, cfg(3'((k + 1) % 6 + 1), 9'h003));
         repeat (60) @(posedge clk);
         rd(lwc_pkg::OFS_RES_LO);
         `CHK(d[3:0], 4'(24'h66915A >> (4 * ((k + 1) % 6))))
      end
      // chain through all wafers settles in one pass
      for (k = 1; k < 10; k++) wr(WF + 12'(4 * k), cfg(3'h2, 9'(26 + 4 * k)));
      wr(lwc_pkg::OFS_DOUT, 32'h0000_0080);
      repeat (60) @(posedge clk);
      rdc(lwc_pkg::OFS_RES_HI, 32'h0000_0055);
      `CHK(discrete_out, 4'h1)
      code <= 9'h000;
      repeat (60) @(posedge clk);
      rdc(lwc_pkg::OFS_RES_LO, 32'h6666_6666);
      rdc(lwc_pkg::OFS_RES_HI, 32'h0000_0066);
      `CHK(discrete_out, 4'h0)
      // disabled: results hold
      wr(lwc_pkg::OFS_CTRL, 32'h0);
      code <= 9'h003;
      repeat (100) @(posedge clk);
      rdc(lwc_pkg::OFS_RES_LO, 32'h6666_6666);
      `CHK(discrete_out, 4'h0)
      print_verdict;
   end
endmodule // lwc_calc_bench
bind lwc_calc lwc_calc_sva u_sva (.*);
